// ==== core/tcc_defines.svh ====
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_OFF_MODE 8'h18
`define TCC_OFF_EN 8'h20
`define TCC_OFF_CNT 8'h24
`define TCC_OFF_CCV 8'h34
`define TCC_OFF_STAT 8'h10
`define TCC_OFF_MASK 8'h0C
`define TCC_MODE_RMASK 16'h00FF
`define TCC_EN_RMASK 16'h000B
`define TCC_F_DIR 1:0
`define TCC_F_PSC 3:2
`define TCC_F_FILT 7:4
`define TCC_F_OCM 6:4
`define TCC_B_EN 0
`define TCC_B_POL 1
`define TCC_B_NPOL 3
`define TCC_RST_16 16'h0000
`endif

// ==== core/tcc_pkg.sv ====
package tcc_pkg;
    typedef enum logic [1:0] {TCC_DIR_OUT, TCC_DIR_TI1, TCC_DIR_TI2, TCC_DIR_TRC} tcc_dir_t;
    typedef enum logic [2:0] {TCC_OC_FREEZE, TCC_OC_HIGH, TCC_OC_LOW, TCC_OC_TOGGLE,
        TCC_OC_FLOW, TCC_OC_FHIGH, TCC_OC_PWM1, TCC_OC_PWM2} tcc_ocm_t;
    typedef enum logic [1:0] {TCC_EDGE_RISE, TCC_EDGE_FALL, TCC_EDGE_RSVD, TCC_EDGE_BOTH}
        tcc_edge_t;
endpackage

// ==== core/tcc_chan1.sv ====
// Implementation choice: the address-and-strobe port.
`include "tcc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_chan1 #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // timer pins
    input wire logic timer_input_one_i,
    input wire logic timer_input_two_i,
    input wire logic trigger_controller_input_i,
    output logic compare_output_pin_o,
    output logic output_drive_enable_o,
    output logic capture_signal_o,
    output logic irq_o
);
    import tcc_pkg::*;

    logic rst_s1_r, rst_n_r;
    logic [7:0] mode_r;
    logic en_r, pol_r, npol_r;
    logic [CNT_W-1:0] cnt_r, ccv_r;
    logic [1:0] stat_r, mask_r;
    logic ref_r;
    logic [2:0] ev_cnt_r;
    logic [4:0] div_cnt_r;
    logic [2:0] agree_r;
    logic filt_r, filt_prev_r, cand_r;
    logic ev_hit, cap_ev, match_ev;

    function automatic logic [4:0] filt_div(input logic [3:0] f);
        case (f)
            4'h0, 4'h1, 4'h2, 4'h3: filt_div = 5'h00;
            4'h4, 4'h5: filt_div = 5'h01;
            4'h6, 4'h7: filt_div = 5'h03;
            4'h8, 4'h9: filt_div = 5'h07;
            4'hA, 4'hB, 4'hC: filt_div = 5'h0F;
            default: filt_div = 5'h1F;
        endcase
    endfunction

    function automatic logic [2:0] filt_n(input logic [3:0] f);
        case (f)
            4'h0: filt_n = 3'h0;
            4'h1: filt_n = 3'h1;
            4'h2: filt_n = 3'h3;
            4'h4, 4'h6, 4'h8, 4'hB, 4'hE: filt_n = 3'h5;
            4'hA, 4'hD: filt_n = 3'h4;
            default: filt_n = 3'h7;
        endcase
    endfunction

    wire logic is_out = (mode_r[`TCC_F_DIR] == TCC_DIR_OUT);
    wire logic [3:0] filt_code = mode_r[`TCC_F_FILT];
    wire logic [2:0] ocm = mode_r[`TCC_F_OCM];
    wire logic wr_mode = wr_i && (addr_i == `TCC_OFF_MODE);
    wire logic wr_en = wr_i && (addr_i == `TCC_OFF_EN);

    // reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // mode register; field meanings depend on direction
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mode_r <= 8'h00;
        end else if (clk_en_i && wr_mode) begin
            mode_r[7:2] <= wdata_i[7:2];
            if (!en_r) begin
                mode_r[`TCC_F_DIR] <= wdata_i[`TCC_F_DIR];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            en_r <= 1'b0;
            pol_r <= 1'b0;
            npol_r <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_en) begin
                en_r <= wdata_i[`TCC_B_EN];
                pol_r <= wdata_i[`TCC_B_POL];
                npol_r <= is_out ? 1'b0 : wdata_i[`TCC_B_NPOL];
            end else if (is_out) begin
                npol_r <= 1'b0;
            end
        end
    end

    // free-running counter stands in for the time base
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r <= CNT_W'(`TCC_RST_16);
        end else if (clk_en_i) begin
            if (wr_i && addr_i == `TCC_OFF_CNT) begin
                cnt_r <= wdata_i[CNT_W-1:0];
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // input selection; trigger input only meaningful with internal trigger
    logic raw_in;
    always_comb begin
        case (mode_r[`TCC_F_DIR])
            TCC_DIR_TI1: raw_in = timer_input_one_i;
            TCC_DIR_TI2: raw_in = timer_input_two_i;
            TCC_DIR_TRC: raw_in = trigger_controller_input_i;
            default: raw_in = 1'b0;
        endcase
    end

    // digital filter: accept a new level after N equal samples at clk/DIV
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            div_cnt_r <= 5'h00;
            agree_r <= 3'h0;
            filt_r <= 1'b0;
            cand_r <= 1'b0;
        end else if (clk_en_i) begin
            if (filt_code == 4'h0) begin
                filt_r <= raw_in;
                div_cnt_r <= 5'h00;
                agree_r <= 3'h0;
            end else if (div_cnt_r != 5'h00) begin
                div_cnt_r <= div_cnt_r - 5'h01;
            end else begin
                div_cnt_r <= filt_div(filt_code);
                cand_r <= raw_in;
                if (raw_in != cand_r || raw_in == filt_r) begin
                    agree_r <= 3'h0;
                end else if (agree_r == filt_n(filt_code) - 3'h1) begin
                    filt_r <= raw_in;
                    agree_r <= 3'h0;
                end else begin
                    agree_r <= agree_r + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            filt_prev_r <= 1'b0;
        end else if (clk_en_i) begin
            filt_prev_r <= filt_r;
        end
    end

    // same polarity pair applies whichever filtered input is routed here
    always_comb begin
        case ({pol_r, npol_r})
            2'b00: ev_hit = filt_r && !filt_prev_r;
            2'b10: ev_hit = !filt_r && filt_prev_r;
            2'b11: ev_hit = filt_r != filt_prev_r;
            default: ev_hit = 1'b0;
        endcase
    end

    // event divider; capture only counts while enabled in input mode
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ev_cnt_r <= 3'h0;
        end else if (clk_en_i) begin
            if (is_out || !en_r) begin
                ev_cnt_r <= 3'h0;
            end else if (ev_hit) begin
                ev_cnt_r <= cap_ev ? 3'h0 : ev_cnt_r + 3'h1;
            end
        end
    end

    assign cap_ev = !is_out && en_r && ev_hit &&
        (ev_cnt_r == ((3'h1 << mode_r[`TCC_F_PSC]) - 3'h1));

    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ccv_r <= CNT_W'(`TCC_RST_16);
            capture_signal_o <= 1'b0;
        end else if (clk_en_i) begin
            capture_signal_o <= cap_ev;
            if (cap_ev) begin
                ccv_r <= cnt_r;
            end else if (wr_i && addr_i == `TCC_OFF_CCV && is_out) begin
                ccv_r <= wdata_i[CNT_W-1:0];
            end
        end
    end

    assign match_ev = is_out && (cnt_r == ccv_r);

    // reference level
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ref_r <= 1'b0;
        end else if (clk_en_i) begin
            case (tcc_ocm_t'(ocm))
                TCC_OC_FREEZE: ref_r <= ref_r;
                TCC_OC_HIGH: ref_r <= match_ev ? 1'b1 : ref_r;
                TCC_OC_LOW: ref_r <= match_ev ? 1'b0 : ref_r;
                TCC_OC_TOGGLE: ref_r <= match_ev ? !ref_r : ref_r;
                TCC_OC_FLOW: ref_r <= 1'b0;
                TCC_OC_FHIGH: ref_r <= 1'b1;
                TCC_OC_PWM1: ref_r <= (cnt_r < ccv_r);
                TCC_OC_PWM2: ref_r <= (cnt_r > ccv_r);
                default: ref_r <= ref_r;
            endcase
        end
    end

    // pin stage registered; pin follows reference one cycle later
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            compare_output_pin_o <= 1'b0;
            output_drive_enable_o <= 1'b0;
        end else if (clk_en_i) begin
            if (is_out && en_r) begin
                compare_output_pin_o <= ref_r ^ pol_r;
                output_drive_enable_o <= 1'b1;
            end else begin
                compare_output_pin_o <= 1'b0;
                output_drive_enable_o <= 1'b0;
            end
        end
    end

    // status: bit0 capture, bit1 compare match; set wins over clear
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_i && addr_i == `TCC_OFF_MASK) begin
                mask_r <= wdata_i[1:0];
            end
            stat_r <= (stat_r & ~((wr_i && addr_i == `TCC_OFF_STAT) ? wdata_i[1:0] : 2'h0))
                | {match_ev, cap_ev};
            irq_o <= |(stat_r & mask_r);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_o <= 16'h0000;
        end else if (clk_en_i) begin
            if (rd_i) begin
                case (addr_i)
                    `TCC_OFF_MODE: rdata_o <= {8'h00, mode_r} & `TCC_MODE_RMASK;
                    `TCC_OFF_EN: rdata_o <= {12'h000, npol_r, 1'b0, pol_r, en_r};
                    `TCC_OFF_CNT: rdata_o <= 16'(cnt_r);
                    `TCC_OFF_CCV: rdata_o <= 16'(ccv_r);
                    `TCC_OFF_STAT: rdata_o <= {14'h0000, stat_r};
                    `TCC_OFF_MASK: rdata_o <= {14'h0000, mask_r};
                    default: rdata_o <= 16'h0000;
                endcase
            end else begin
                rdata_o <= 16'h0000;
            end
        end
    end

    sequence s_wr_dir_while_en;
        wr_mode && en_r && clk_en_i;
    endsequence

    a_dir_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        s_wr_dir_while_en |=> $stable(mode_r[1:0])) else $error("dir changed while enabled");
    a_npol_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        is_out && $past(is_out) |-> !npol_r) else $error("npol set in output mode");
    a_pin_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i && !en_r |=> !output_drive_enable_o && !compare_output_pin_o)
        else $error("pin driven while disabled");
    a_pin_pol: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i && en_r && is_out |=> output_drive_enable_o &&
        compare_output_pin_o == ($past(ref_r) ^ $past(pol_r)))
        else $error("pin level wrong");
    a_cap_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i && cap_ev |=> ccv_r == $past(cnt_r)) else $error("capture not stored");
    a_cap_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        !en_r |-> !cap_ev) else $error("capture while disabled");
    a_force_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i && ocm == 3'h5 |=> ref_r) else $error("force high failed");
    a_rsvd_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        {pol_r, npol_r} == 2'b01 |-> !ev_hit) else $error("reserved edge used");
    a_psc_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        !is_out && en_r && ev_hit && mode_r[3:2] == 2'h0 |-> cap_ev)
        else $error("prescale 1 missed");
    a_irq_lvl: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i |=> irq_o == |($past(stat_r) & $past(mask_r))) else $error("irq wrong");

    // a frozen clock enable must hold the counter, the mode register and the compare value
    sequence s_frozen;
        !clk_en_i;
    endsequence

    sequence s_cnt_free;
        clk_en_i && !(wr_i && addr_i == `TCC_OFF_CNT);
    endsequence

    a_freeze_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        s_frozen |=> $stable(cnt_r) && $stable(mode_r) && $stable(ccv_r))
        else $error("state moved while frozen");
    a_cnt_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        s_cnt_free |=> cnt_r == $past(cnt_r) + 1'b1) else $error("counter did not step");
    a_rd_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i && !rd_i |=> rdata_o == 16'h0000) else $error("read data not idle");
    a_cap_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i |=> capture_signal_o == $past(cap_ev)) else $error("capture pulse wrong");
    a_filt_bypass: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i && filt_code == 4'h0 |=> filt_r == $past(raw_in))
        else $error("unfiltered input not sampled");
    a_match_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        clk_en_i && match_ev |=> stat_r[1]) else $error("match flag not set");
endmodule
`default_nettype wire

// ==== test/tcc_pins_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
    // control from the bench
    input wire logic sys_clk_i,
    input wire logic [1:0] sel_i,
    input wire logic lvl_i,
    // timer pins
    output logic timer_input_one_o,
    output logic timer_input_two_o,
    output logic trigger_controller_input_o
);
    logic tog_r;
    initial tog_r = 1'b0;
    always @(posedge sys_clk_i) begin
        tog_r <= ~tog_r;
    end
    // unselected pins chatter every cycle, so a wrong input mapping shows up as extra captures
    assign timer_input_one_o = (sel_i == 2'h1) ? lvl_i : tog_r;
    assign timer_input_two_o = (sel_i == 2'h2) ? lvl_i : tog_r;
    assign trigger_controller_input_o = (sel_i == 2'h3) ? lvl_i : tog_r;
endmodule
`default_nettype wire

// ==== test/tcc_chan1_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_chan1_tb;
    import tcc_pkg::*;
    logic sys_clk_i, rstn_i, wr_i, rd_i, lvl, tin1, tin2, trg, pin, oe, cap, irq, ce;
    logic [7:0] addr_i;
    logic [15:0] wdata_i, rdata_o, caps, d, h, l, e, m;
    logic [1:0] sel;
    int mismatches, compares;
    int fc[3] = '{3, 10, 15};
    int fs[3] = '{4, 60, 200};
    int fl[3] = '{20, 120, 400};
    logic [15:0] pols[3] = '{16'h0001, 16'h0003, 16'h000B};
    tcc_chan1 uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(ce),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_input_one_i(tin1), .timer_input_two_i(tin2),
        .trigger_controller_input_i(trg), .compare_output_pin_o(pin),
        .output_drive_enable_o(oe), .capture_signal_o(cap), .irq_o(irq));
    tcc_pins_model pins (.sys_clk_i(sys_clk_i), .sel_i(sel), .lvl_i(lvl),
        .timer_input_one_o(tin1), .timer_input_two_o(tin2), .trigger_controller_input_o(trg));
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (cap === 1'b1) caps <= caps + 16'h0001;
    end
    task give_verdict;
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp(input logic [15:0] g, input logic [15:0] x);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task cmp_rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
        compares++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t got %h outside %h..%h", $time, g, lo, hi);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task chk(input logic [7:0] a, input logic [15:0] x);
        rd(a, d);
        cmp(d, x);
    endtask
    // counts captures separately in the high and the low phase of one input pulse
    task pulse(input int w);
        logic [15:0] c;
        c = caps;
        @(posedge sys_clk_i);
        lvl <= 1'b1;
        repeat (w) @(posedge sys_clk_i);
        h = h + (caps - c);
        c = caps;
        lvl <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        l = l + (caps - c);
    endtask
    task setup(input logic [15:0] mode, input logic [15:0] en);
        wr(8'h20, 16'h0000);
        wr(8'h18, mode);
        wr(8'h20, en);
        h = 16'h0000;
        l = 16'h0000;
    endtask
    task outchk(input logic eo, input logic ep);
        repeat (5) @(posedge sys_clk_i);
        #1 cmp({14'h0000, oe, pin}, {14'h0000, eo, ep});
    endtask
    initial begin
        #1000000;
        mismatches++;
        $display("[ERR] %0t run did not finish", $time);
        give_verdict;
    end
    initial begin
        rstn_i = 1'b0;
        ce = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 16'h0000;
        lvl = 1'b0;
        sel = 2'h1;
        caps = 16'h0000;
        mismatches = 0;
        compares = 0;
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk(8'h20, 16'h0000);
        chk(8'h18, 16'h0000);
        chk(8'h44, 16'h0000);
        wr(8'h18, 16'hFFFF);
        chk(8'h18, 16'h00FF);
        wr(8'h20, 16'hFFFF);
        chk(8'h20, 16'h000B);
        wr(8'h18, 16'h0000);
        chk(8'h18, 16'h0003);
        setup(16'h0001, 16'h0001);
        wr(8'h24, 16'h1000);
        pulse(10);
        rd(8'h34, d);
        cmp_rng(d, 16'h1001, 16'h1006);
        wr(8'h0C, 16'h0001);
        repeat (3) @(posedge sys_clk_i);
        cmp({15'h0000, irq}, 16'h0001);
        rd(8'h10, d);
        cmp(d & 16'h0001, 16'h0001);
        wr(8'h10, 16'h0001);
        repeat (3) @(posedge sys_clk_i);
        cmp({15'h0000, irq}, 16'h0000);
        for (int pi = 0; pi < 3; pi++) begin
            for (int p = 0; p < 4; p++) begin
                setup(16'h0001 | (16'(p) << 2), pols[pi]);
                repeat (8) pulse(10);
                e = (pi == 2) ? 16'h0010 : 16'h0008;
                cmp(h + l, e >> p);
                if (p == 0) cmp(h, (pi == 1) ? 16'h0000 : 16'h0008);
            end
        end
        setup(16'h0001, 16'h0000);
        repeat (4) pulse(10);
        cmp(h + l, 16'h0000);
        for (int dd = 1; dd < 4; dd++) begin
            sel <= 2'(dd);
            setup(16'(dd), 16'h0003);
            repeat (4) pulse(10);
            cmp(l, 16'h0004);
            cmp(h, 16'h0000);
        end
        sel <= 2'h1;
        for (int f = 0; f < 3; f++) begin
            setup(16'h0001 | (16'(fc[f]) << 4), 16'h0001);
            pulse(fs[f]);
            cmp(h + l, 16'h0000);
            pulse(fl[f]);
            cmp(h + l, 16'h0001);
            repeat (600) @(posedge sys_clk_i);
        end
        wr(8'h20, 16'h0000);
        wr(8'h18, 16'h0000);
        outchk(1'b0, 1'b0);
        wr(8'h34, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            for (int pp = 0; pp < 2; pp++) begin
                m = 16'h0040 + (16'(k) << 4);
                wr(8'h18, m);
                wr(8'h20, (pp == 1) ? 16'h0003 : 16'h0001);
                // force low, force high, pwm1 and pwm2 against a zero compare value
                outchk(1'b1, k[0] ^ pp[0]);
            end
        end
        wr(8'h20, 16'h000B);
        chk(8'h20, 16'h0003);
        wr(8'h20, 16'h0000);
        outchk(1'b0, 1'b0);
        // counter must not move during twenty frozen cycles
        wr(8'h24, 16'h2000);
        ce <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        ce <= 1'b1;
        rd(8'h24, d);
        cmp(d, 16'h2001);
        give_verdict;
    end
endmodule
`default_nettype wire
